// file: rtl/reclk_cfg_pkg.sv
// Constants, field positions and carrier types for the reclocker configuration bank.
// Assumes an 8-bit register port from a serial front end on the same clock.
package reclk_cfg_pkg;
	localparam int         ADDR_W             = 8;
	localparam int         DATA_W             = 8;
	localparam int         NUM_INPUTS         = 4;
	localparam logic [7:0] ADDR_SIGNAL_LOSS   = 8'h06;
	localparam logic [7:0] ADDR_INPUT_MUX     = 8'h07;
	localparam logic [7:0] ADDR_FIRST_OUT     = 8'h09;
	localparam logic [7:0] ADDR_SECOND_DE     = 8'h0a;
	localparam logic [7:0] ADDR_SECOND_CTRL   = 8'h0c;
	localparam logic [7:0] ADDR_ALARM_CLEAR   = 8'h85;
	localparam int         THRESH_LSB         = 5;
	localparam int         MUTE_DIS_BIT       = 3;
	localparam int         CLK_EN_BIT         = 0;
	localparam int         SWING_LSB          = 2;
	localparam int         FIRST_DE_LSB       = 0;
	localparam int         SECOND_DE_LSB      = 4;
	localparam int         SECOND_EN_BIT      = 2;
	localparam int         ALARM_CLEAR_BIT    = 0;
	localparam logic [7:0] RST_SIGNAL_LOSS    = 8'h00;
	localparam logic [7:0] RST_INPUT_MUX      = 8'h00;
	localparam logic [7:0] RST_FIRST_OUT      = 8'h00;
	localparam logic [7:0] RST_SECOND_DE      = 8'h00;
	localparam logic [7:0] RST_SECOND_CTRL    = 8'h00;
	localparam logic [7:0] RST_ALARM_CLEAR    = 8'h00;
	localparam logic [1:0] LEVEL_0DB          = 2'h0;
	localparam logic [1:0] LEVEL_2DB          = 2'h1;
	localparam logic [1:0] LEVEL_4DB          = 2'h2;
	localparam logic [1:0] LEVEL_6DB          = 2'h3;

	typedef enum logic [2:0] {
		PIN_LOW   = 3'b001,
		PIN_FLOAT = 3'b010,
		PIN_HIGH  = 3'b100
	} tri_level_t;

	typedef enum logic [2:0] {
		MODE_HARDWARE = 3'b001,
		MODE_SERIAL   = 3'b010,
		MODE_EEPROM   = 3'b100
	} control_mode_t;

	// Three-level pin detector: is_high, is_low (neither means floating)
	typedef struct packed {
		logic is_high;
		logic is_low;
	} tri_pin_t;

	typedef struct packed {
		logic       second_enable;
		logic       clock_on_second;
		logic [1:0] first_swing;
		logic [1:0] second_swing;
		logic [1:0] first_deemphasis;
		logic [1:0] second_deemphasis;
		logic [1:0] input_equalizer;
		logic       retimer_bypass;
		logic       outputs_disabled;
		logic [1:0] input_select;
	} output_cfg_t;
endpackage

// file: rtl/reclk_cfg.sv
// Register bank and strap decode for a four-input reclocker control core.
// Assumes the serial front end delivers one-cycle write/read strobes on i_ref_clk,
// and that the three-level pin detectors are asynchronous, hence synchronised here.

module reclk_cfg
	import reclk_cfg_pkg::*;
(
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_reset_n,
	input  wire logic                    i_wr_en,
	input  wire logic                    i_rd_en,
	input  wire logic [ADDR_W-1:0]       i_addr,
	input  wire logic [DATA_W-1:0]       i_wdata,
	input  wire logic                    i_eeprom_enter,
	input  wire logic [NUM_INPUTS-1:0]   i_below_threshold,
	input  wire logic [NUM_INPUTS-1:0]   i_input_powered,
	input  wire tri_pin_t                i_mode_sel_pin,
	input  wire tri_pin_t                i_second_output_or_clock_pin,
	input  wire tri_pin_t                i_input_equalizer_pin,
	input  wire tri_pin_t                i_output_emphasis_pin,
	input  wire tri_pin_t                i_retimer_skip_pin,
	input  wire tri_pin_t                i_output_disable_pin,
	output logic [DATA_W-1:0]            o_rdata,
	output logic                         o_rvalid,
	output logic [2:0]                   o_signal_loss_threshold,
	output logic [NUM_INPUTS-1:0]        o_signal_loss,
	output logic [NUM_INPUTS-1:0]        o_input_mute,
	output logic                         o_alarm_output_pin,
	output control_mode_t                o_control_mode,
	output output_cfg_t                  o_output_cfg
);

	// Synchronisers for the three-level detectors: six pins, two bits each
	localparam int NPIN = 6;
	logic [2*NPIN-1:0] pin_meta_reg;
	logic [2*NPIN-1:0] pin_sync_reg;
	logic [NUM_INPUTS-1:0] below_meta_reg;
	logic [NUM_INPUTS-1:0] below_sync_reg;
	logic [NUM_INPUTS-1:0] powered_meta_reg;
	logic [NUM_INPUTS-1:0] powered_sync_reg;

	logic [7:0] signal_loss_config_reg;
	logic [7:0] input_mux_reg;
	logic [7:0] first_output_control_reg;
	logic [7:0] second_output_deemphasis_reg;
	logic [7:0] second_output_control_reg;
	logic [7:0] alarm_clear_reg;
	logic [NUM_INPUTS-1:0] signal_loss_reg;
	logic [NUM_INPUTS-1:0] signal_loss_next;
	logic       eeprom_mode_reg;
	logic       clear_pulse;
	control_mode_t mode_next;

	tri_level_t mode_lvl;
	tri_level_t second_lvl;
	tri_level_t eq_lvl;
	tri_level_t de_lvl;
	tri_level_t skip_lvl;
	tri_level_t dis_lvl;

	function automatic tri_level_t decode_tri(input logic [1:0] hl);
		if (hl[1])
			decode_tri = PIN_HIGH;
		else if (hl[0])
			decode_tri = PIN_LOW;
		else
			decode_tri = PIN_FLOAT;
	endfunction

	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			pin_meta_reg     <= '0;
			pin_sync_reg     <= '0;
			below_meta_reg   <= '0;
			below_sync_reg   <= '0;
			powered_meta_reg <= '0;
			powered_sync_reg <= '0;
		end else begin
			pin_meta_reg     <= {i_mode_sel_pin, i_second_output_or_clock_pin,
				i_input_equalizer_pin, i_output_emphasis_pin,
				i_retimer_skip_pin, i_output_disable_pin};
			pin_sync_reg     <= pin_meta_reg;
			below_meta_reg   <= i_below_threshold;
			below_sync_reg   <= below_meta_reg;
			powered_meta_reg <= i_input_powered;
			powered_sync_reg <= powered_meta_reg;
		end
	end

	assign mode_lvl   = decode_tri(pin_sync_reg[11:10]);
	assign second_lvl = decode_tri(pin_sync_reg[9:8]);
	assign eq_lvl     = decode_tri(pin_sync_reg[7:6]);
	assign de_lvl     = decode_tri(pin_sync_reg[5:4]);
	assign skip_lvl   = decode_tri(pin_sync_reg[3:2]);
	assign dis_lvl    = decode_tri(pin_sync_reg[1:0]);

	// Register writes
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			signal_loss_config_reg       <= RST_SIGNAL_LOSS;
			input_mux_reg                <= RST_INPUT_MUX;
			first_output_control_reg     <= RST_FIRST_OUT;
			second_output_deemphasis_reg <= RST_SECOND_DE;
			second_output_control_reg    <= RST_SECOND_CTRL;
			alarm_clear_reg              <= RST_ALARM_CLEAR;
		end else if (i_wr_en) begin
			unique case (i_addr)
				ADDR_SIGNAL_LOSS: signal_loss_config_reg <= i_wdata;
				ADDR_INPUT_MUX:   input_mux_reg <= i_wdata;
				ADDR_FIRST_OUT:   first_output_control_reg <= i_wdata;
				ADDR_SECOND_DE:   second_output_deemphasis_reg <= i_wdata;
				ADDR_SECOND_CTRL: second_output_control_reg <= i_wdata;
				ADDR_ALARM_CLEAR: alarm_clear_reg <= i_wdata;
				default: ;
			endcase
		end
	end

	// Clear acts on the falling step of the clear bit, completing the one-then-zero sequence
	assign clear_pulse = i_wr_en && (i_addr == ADDR_ALARM_CLEAR)
		&& alarm_clear_reg[ALARM_CLEAR_BIT] && !i_wdata[ALARM_CLEAR_BIT];

	// Set wins over clear so a loss arriving during the clear write is kept
	always_comb begin
		signal_loss_next = signal_loss_reg;
		if (clear_pulse)
			signal_loss_next = '0;
		signal_loss_next = signal_loss_next | (below_sync_reg & powered_sync_reg);
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n)
			signal_loss_reg <= '0;
		else
			signal_loss_reg <= signal_loss_next;
	end

	// EEPROM mode is latched once entered from two-wire control; exits on reset or when the mode pin leaves low
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n)
			eeprom_mode_reg <= 1'b0;
		else if (mode_lvl == PIN_LOW && i_eeprom_enter)
			eeprom_mode_reg <= 1'b1;
		else if (mode_lvl != PIN_LOW)
			eeprom_mode_reg <= 1'b0;
	end

	always_comb begin
		unique case (mode_lvl)
			PIN_FLOAT: mode_next = MODE_HARDWARE;
			PIN_HIGH:  mode_next = MODE_SERIAL;
			PIN_LOW:   mode_next = eeprom_mode_reg ? MODE_EEPROM : MODE_SERIAL;
			default:   mode_next = MODE_SERIAL;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n)
			o_control_mode <= MODE_SERIAL;
		else
			o_control_mode <= mode_next;
	end

	function automatic logic [1:0] hw_level(input tri_level_t lvl, input logic [1:0] mid);
		unique case (lvl)
			PIN_HIGH:  hw_level = LEVEL_6DB;
			PIN_FLOAT: hw_level = mid;
			default:   hw_level = LEVEL_0DB;
		endcase
	endfunction

	// Output configuration: swing, input select and threshold from registers in all modes; straps set the rest in hardware mode
	// In serial modes second enable, clock and de-emphasis come from registers; equalizer, bypass and disable are forced to zero
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			o_output_cfg            <= '0;
			o_signal_loss_threshold <= '0;
		end else begin
			o_signal_loss_threshold <= signal_loss_config_reg[THRESH_LSB +: 3];
			o_output_cfg.first_swing  <= first_output_control_reg[SWING_LSB +: 2];
			o_output_cfg.second_swing <= first_output_control_reg[SWING_LSB +: 2];
			o_output_cfg.input_select <= input_mux_reg[1:0];
			if (mode_next == MODE_HARDWARE) begin
				o_output_cfg.second_enable     <= second_lvl != PIN_LOW;
				o_output_cfg.clock_on_second   <= second_lvl == PIN_HIGH;
				o_output_cfg.first_deemphasis  <= hw_level(de_lvl, LEVEL_4DB);
				o_output_cfg.second_deemphasis <= hw_level(de_lvl, LEVEL_4DB);
				o_output_cfg.input_equalizer   <= hw_level(eq_lvl, LEVEL_2DB);
				o_output_cfg.retimer_bypass    <= skip_lvl == PIN_HIGH;
				o_output_cfg.outputs_disabled  <= dis_lvl == PIN_HIGH;
			end else begin
				o_output_cfg.second_enable     <= second_output_control_reg[SECOND_EN_BIT];
				o_output_cfg.clock_on_second   <= signal_loss_config_reg[CLK_EN_BIT];
				o_output_cfg.first_deemphasis  <= first_output_control_reg[FIRST_DE_LSB +: 2];
				o_output_cfg.second_deemphasis <=
					second_output_deemphasis_reg[SECOND_DE_LSB +: 2];
				o_output_cfg.input_equalizer   <= LEVEL_0DB;
				o_output_cfg.retimer_bypass    <= 1'b0;
				o_output_cfg.outputs_disabled  <= 1'b0;
			end
		end
	end

	// Alarm and mute outputs
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			o_signal_loss      <= '0;
			o_input_mute       <= '0;
			o_alarm_output_pin <= 1'b0;
		end else begin
			o_signal_loss      <= signal_loss_next;
			o_input_mute       <= signal_loss_config_reg[MUTE_DIS_BIT] ? '0 : signal_loss_next;
			o_alarm_output_pin <= (mode_next != MODE_HARDWARE) && (|signal_loss_next);
		end
	end

	// Read path: one cycle after the strobe; unmapped addresses read zero
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			o_rdata  <= '0;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_rd_en;
			if (i_rd_en) begin
				unique case (i_addr)
					ADDR_SIGNAL_LOSS: o_rdata <= signal_loss_config_reg;
					ADDR_INPUT_MUX:   o_rdata <= input_mux_reg;
					ADDR_FIRST_OUT:   o_rdata <= first_output_control_reg;
					ADDR_SECOND_DE:   o_rdata <= second_output_deemphasis_reg;
					ADDR_SECOND_CTRL: o_rdata <= second_output_control_reg;
					ADDR_ALARM_CLEAR: o_rdata <= {alarm_clear_reg[7:4], signal_loss_reg};
					default:          o_rdata <= '0;
				endcase
			end
		end
	end

endmodule // reclk_cfg

// file: tb/reclk_cfg_monitor.sv
// Checker for reclk_cfg: strobes, alarms, modes and strap decode seen at the ports.
// Assumes one clock domain and the synchronous active-low reset of the bank.
module reclk_cfg_monitor
	import reclk_cfg_pkg::*;
(
	input wire logic                  i_ref_clk,
	input wire logic                  i_reset_n,
	input wire logic                  i_wr_en,
	input wire logic [ADDR_W-1:0]     i_addr,
	input wire logic [DATA_W-1:0]     i_wdata,
	input wire logic [NUM_INPUTS-1:0] i_input_powered,
	input wire tri_pin_t              i_mode_sel_pin,
	input wire logic [2:0]            o_signal_loss_threshold,
	input wire logic [NUM_INPUTS-1:0] o_signal_loss,
	input wire logic [NUM_INPUTS-1:0] o_input_mute,
	input wire logic                  o_alarm_output_pin,
	input wire control_mode_t         o_control_mode,
	input wire output_cfg_t           o_output_cfg
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_reset_n);
	AST_THRESH: assert property (i_wr_en && i_addr == ADDR_SIGNAL_LOSS |-> ##2
		o_signal_loss_threshold == $past(i_wdata[7:5], 2)) else $error("threshold lost");
	AST_SECOND: assert property (i_wr_en && i_addr == ADDR_SECOND_CTRL &&
		o_control_mode == MODE_SERIAL |-> ##2 o_output_cfg.second_enable ==
		$past(i_wdata[SECOND_EN_BIT], 2)) else $error("second output enable lost");
	AST_MUTE: assert property ($stable(o_signal_loss) |->
		(o_input_mute & ~o_signal_loss) == '0) else $error("mute without alarm");
	AST_NOPOWER: assert property ((o_signal_loss & ~$past(o_signal_loss) &
		~i_input_powered & ~$past(i_input_powered, 4)) == '0) else $error("unpowered alarm");
	AST_HW_ALARM: assert property (o_control_mode == MODE_HARDWARE &&
		$past(o_control_mode) == MODE_HARDWARE |-> !o_alarm_output_pin) else $error("alarm pin");
	AST_HW_DE: assert property ((o_control_mode == MODE_HARDWARE)[*3] |->
		o_output_cfg.first_deemphasis == o_output_cfg.second_deemphasis &&
		o_output_cfg.first_deemphasis != LEVEL_2DB) else $error("strap emphasis");
	AST_SER_STRAP: assert property ((o_control_mode == MODE_SERIAL)[*3] |->
		o_output_cfg.input_equalizer == LEVEL_0DB && !o_output_cfg.retimer_bypass &&
		!o_output_cfg.outputs_disabled) else $error("strap decode outside hardware mode");
	AST_MODE_HW: assert property ((i_mode_sel_pin == 2'h0)[*5] |->
		o_control_mode == MODE_HARDWARE) else $error("floating mode pin not decoded");
	COV_ALARM: cover property ($rose(o_signal_loss[0]));
	COV_HW: cover property (o_control_mode == MODE_HARDWARE);
	COV_EEPROM: cover property (o_control_mode == MODE_EEPROM);
endmodule // reclk_cfg_monitor

bind reclk_cfg reclk_cfg_monitor mon (.i_ref_clk, .i_reset_n, .i_wr_en, .i_addr, .i_wdata,
	.i_input_powered, .i_mode_sel_pin, .o_signal_loss_threshold, .o_signal_loss,
	.o_input_mute, .o_alarm_output_pin, .o_control_mode, .o_output_cfg);

// file: tb/reclk_host_model.sv
// Host controller stand-in issuing register traffic on the bank's strobe port.
// Assumes a strobe is taken at the rising edge after it is raised.
module reclk_host_model
	import reclk_cfg_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic [7:0]  i_rdata,
	input  wire logic        i_rvalid,
	output logic             o_wr_en,
	output logic             o_rd_en,
	output logic [7:0]       o_addr,
	output logic [7:0]       o_wdata,
	output logic             o_eeprom_enter
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{o_wr_en, o_rd_en, o_eeprom_enter} = 3'h0;
		{o_addr, o_wdata} = 16'h0;
	end
	// Released lines flip so stale address or data never passes for a live one
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_ref_clk);
		{o_wr_en, o_addr, o_wdata} = {1'b1, a, d};
		@(negedge i_ref_clk);
		{o_wr_en, o_addr, o_wdata} = {1'b0, ~a, ~d};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_ref_clk);
		{o_rd_en, o_addr} = {1'b1, a};
		@(negedge i_ref_clk);
		{o_rd_en, o_addr} = {1'b0, ~a};
		for (int n = 0; n < 3 && !i_rvalid; n++)
			@(negedge i_ref_clk);
		d = i_rvalid ? i_rdata : 8'hxx;
	endtask
	task automatic alarm_clear();
		wr(ADDR_ALARM_CLEAR, 8'h01);
		wr(ADDR_ALARM_CLEAR, 8'h00);
	endtask
	task automatic enter_eeprom();
		@(negedge i_ref_clk);
		o_eeprom_enter = 1'b1;
		@(negedge i_ref_clk);
		o_eeprom_enter = 1'b0;
	endtask
endmodule // reclk_host_model

// file: tb/reclk_cfg_test.sv
// Self-checking bench for reclk_cfg: registers, alarms, strap decode and control modes.
// Assumes a 40 MHz i_ref_clk; the host model carries all register traffic.
module reclk_cfg_test
	import reclk_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic		i_ref_clk, i_reset_n, i_wr_en, i_rd_en, i_eeprom_enter, o_rvalid;
	logic		o_alarm_output_pin;
	logic [7:0]	i_addr, i_wdata, o_rdata, rd;
	logic [3:0]	i_below_threshold, i_input_powered, o_signal_loss, o_input_mute;
	logic [2:0]	o_signal_loss_threshold;
	tri_pin_t	i_mode_sel_pin, i_second_output_or_clock_pin, i_input_equalizer_pin;
	tri_pin_t	i_output_emphasis_pin, i_retimer_skip_pin, i_output_disable_pin;
	control_mode_t	o_control_mode;
	output_cfg_t	o_output_cfg;
	int		err_total, n_tests;
	localparam logic [1:0] DE_EXP [3] = '{LEVEL_0DB, LEVEL_4DB, LEVEL_6DB};
	localparam logic [1:0] EQ_EXP [3] = '{LEVEL_0DB, LEVEL_2DB, LEVEL_6DB};
	localparam logic [7:0] REGS [6] = '{ADDR_SIGNAL_LOSS, ADDR_INPUT_MUX, ADDR_FIRST_OUT,
		ADDR_SECOND_DE, ADDR_SECOND_CTRL, ADDR_ALARM_CLEAR};
	reclk_cfg dut (.i_ref_clk, .i_reset_n, .i_wr_en, .i_rd_en, .i_addr, .i_wdata,
		.i_eeprom_enter, .i_below_threshold, .i_input_powered, .i_mode_sel_pin,
		.i_second_output_or_clock_pin, .i_input_equalizer_pin, .i_output_emphasis_pin,
		.i_retimer_skip_pin, .i_output_disable_pin, .o_rdata, .o_rvalid,
		.o_signal_loss_threshold, .o_signal_loss, .o_input_mute, .o_alarm_output_pin,
		.o_control_mode, .o_output_cfg);
	reclk_host_model host (.i_ref_clk, .i_rdata(o_rdata), .i_rvalid(o_rvalid),
		.o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_addr(i_addr), .o_wdata(i_wdata),
		.o_eeprom_enter(i_eeprom_enter));
	always #12.5 i_ref_clk = ~i_ref_clk;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		if (err_total == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Floating is both detector bits low: the pin is simply left undriven
	function automatic tri_pin_t lvl(input int v);
		return '{is_high: v == 2, is_low: v == 0};
	endfunction
	task automatic straps(input int m, input int p);
		i_mode_sel_pin = lvl(m);
		{i_second_output_or_clock_pin, i_input_equalizer_pin} = {lvl(p), lvl(p)};
		{i_output_emphasis_pin, i_retimer_skip_pin, i_output_disable_pin} = {3{lvl(p)}};
		repeat (5) @(negedge i_ref_clk);
	endtask
	initial begin
		{i_ref_clk, i_reset_n, err_total, n_tests} = '0;
		{i_below_threshold, i_input_powered} = 8'h03;
		straps(2, 1);
		@(negedge i_ref_clk);
		i_reset_n = 1'b1;
		foreach (REGS[k]) begin
			host.rd(REGS[k], rd);
			check(rd, 8'h00);
		end
		check(o_output_cfg, '0);
		check(o_control_mode, MODE_SERIAL);
		host.wr(ADDR_SIGNAL_LOSS, 8'he1);
		host.wr(ADDR_SECOND_CTRL, 8'h04);
		host.wr(ADDR_INPUT_MUX, 8'h02);
		host.wr(8'h33, 8'h5a);
		host.rd(8'h33, rd);
		check(rd, 8'h00);
		check(o_signal_loss_threshold, 3'h7);
		check({o_output_cfg.second_enable, o_output_cfg.clock_on_second}, 2'h3);
		check(o_output_cfg.input_select, 2'h2);
		for (int i = 0; i < 4; i++) begin
			host.wr(ADDR_FIRST_OUT, {4'h0, 2'(i % 3), 2'(i)});
			host.wr(ADDR_SECOND_DE, 8'(i << 4));
			repeat (2) @(negedge i_ref_clk);
			check({o_output_cfg.first_deemphasis, o_output_cfg.second_deemphasis}, {2{2'(i)}});
			check({o_output_cfg.first_swing, o_output_cfg.second_swing}, {2{2'(i % 3)}});
		end
		host.wr(ADDR_SIGNAL_LOSS, 8'h00);
		i_below_threshold = 4'h5;
		repeat (5) @(negedge i_ref_clk);
		check({o_signal_loss, o_input_mute, 3'h0, o_alarm_output_pin}, 9'h111);
		i_below_threshold = 4'h0;
		host.wr(ADDR_ALARM_CLEAR, 8'h01);
		host.rd(ADDR_ALARM_CLEAR, rd);
		check(rd[3:0], 4'h1);
		host.wr(ADDR_ALARM_CLEAR, 8'h00);
		repeat (2) @(negedge i_ref_clk);
		check(o_signal_loss, 4'h0);
		host.wr(ADDR_SIGNAL_LOSS, 8'h08);
		i_below_threshold = 4'h1;
		repeat (5) @(negedge i_ref_clk);
		check({o_signal_loss, o_input_mute}, 8'h10);
		host.alarm_clear();
		repeat (2) @(negedge i_ref_clk);
		check(o_signal_loss, 4'h1);
		for (int p = 0; p < 3; p++) begin
			straps(1, p);
			check({o_control_mode, 3'h0, o_alarm_output_pin}, {MODE_HARDWARE, 4'h0});
			check({o_output_cfg.first_deemphasis, o_output_cfg.second_deemphasis}, {2{DE_EXP[p]}});
			check(o_output_cfg.input_equalizer, EQ_EXP[p]);
			check({o_output_cfg.second_enable, o_output_cfg.clock_on_second}, {p > 0, p == 2});
			check({o_output_cfg.retimer_bypass, o_output_cfg.outputs_disabled}, {2{p == 2}});
		end
		straps(0, 1);
		host.enter_eeprom();
		repeat (2) @(negedge i_ref_clk);
		check(o_control_mode, MODE_EEPROM);
		straps(2, 1);
		check({o_control_mode, o_alarm_output_pin}, {MODE_SERIAL, 1'b1});
		test_done();
	end
	initial begin
		#(25 * 3000);
		err_total++;
		test_done();
	end
endmodule // reclk_cfg_test
